// ### rtl/wdt_pkg.sv
package wdt_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_WD_CONTROL   = 8'h00;
	localparam logic [7:0] ADDR_CLOCK_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_EXT_INT_EN   = 8'h08;
	localparam logic [7:0] ADDR_POWER_MGMT   = 8'h0c;
	localparam logic [7:0] ADDR_FLASH_CTRL   = 8'h10;
	localparam logic [7:0] ADDR_STATUS       = 8'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_RESTART     = 0;
	localparam int BIT_RST_ENABLE  = 1;
	localparam int BIT_RST_FLAG    = 2;
	localparam int BIT_INT_FLAG    = 3;
	localparam int BIT_WD_INT_EN   = 4;
	localparam int BIT_WD_SEL_LO   = 6;
	localparam int BIT_CD_LO       = 0;
	localparam int BIT_MULT_FACTOR = 2;
	localparam int BIT_MULT_EN     = 4;
	localparam int BIT_XTAL_RESTART = 5;

	// ----------------------------------------------------------------
	// reset values, commands and response codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CLOCK_CTRL_RST    = 8'h00;
	localparam logic [1:0] CD_RST            = 2'h2;
	localparam logic [7:0] SYS_RESET_CMD     = 8'h5a;
	localparam logic [1:0] RESP_OKAY         = 2'h0;
	localparam logic [1:0] RESP_SLVERR       = 2'h2;

	// ----------------------------------------------------------------
	// counts in system clock cycles
	// ----------------------------------------------------------------
	localparam int        WIDTH_CNT        = 37;
	localparam int        EXP_BASE_CD10    = 17;
	localparam int        EXP_BASE_CD11    = 27;
	localparam int        EXP_BASE_4X      = 15;
	localparam int        EXP_BASE_2X      = 16;
	localparam int        EXP_STEP         = 3;
	localparam logic [19:0] DELAY_4X       = 20'h00080;
	localparam logic [19:0] DELAY_2X       = 20'h00100;
	localparam logic [19:0] DELAY_CD10     = 20'h00200;
	localparam logic [19:0] DELAY_CD11     = 20'h80000;
	localparam int        XTAL_WARM_CYCLES = 65536;
	localparam int        SWRST_EXT_CYCLES = 90;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       int_flag;
		logic       rst_flag;
		logic       rst_enable;
	} wd_ctrl_t;

	typedef enum logic [2:0] {
		WD_COUNT = 3'b001,
		WD_DELAY = 3'b010,
		WD_FIRE  = 3'b100
	} wd_state_t;

endpackage : wdt_pkg

// ### rtl/watchdog_system_reset.sv
// Functional notes
// RQ1 - divide 10: interval 2^17..2^26 by select, reset 512 cycles later.
// RQ2 - divide 11: interval 2^27..2^36 by select, reset 524288 cycles later.
// RQ3 - watchdog reset issued only while reset-enable bit is set.
// RQ4 - writing one to restart bit begins a full new interval.
// RQ5 - with reset masked, interval timeouts repeat periodically.
// RQ6 - interval expiry sets the interrupt flag, control bit 3.
// RQ7 - watchdog reset sets the reset flag, control bit 2.
// RQ8 - interrupt request forwarded only while extended enable bit 4 set.
// RQ9 - all timeouts counted in system clock cycles.
// RQ10 - startup counter counts 65536 crystal cycles before crystal is used.
// RQ11 - warm-up applied at power-up and on each crystal restart after stop.
// RQ12 - setting multiplier enable imposes a watchdog-timed startup delay.
// RQ13 - enabled watchdog interrupt wakes the system from idle.
// RQ14 - writing reset command to flash control starts a system reset.
// RQ15 - software reset lasts about 90 external clocks, reset pin high.
// RQ16 - afterwards reset pin driven low, execution restarts at 0000h.
// RQ17 - divide 00: 2^15.. +128 at 4X, 2^16.. +256 at 2X.
// RQ18 - any reset returns the default divide ratio.
// RQ19 - interval select lives in clock control bits 7:6.
// RQ20 - software clears the interrupt flag; servicing does not.
// RQ21 - restart clears interval and delay counts.
// RQ22 - reset flag survives its reset, cleared only by software write; the code also clears it on SRST.
module watchdog_system_reset
	import wdt_pkg::*;
#(
	parameter int XTAL_WARM = XTAL_WARM_CYCLES,
	parameter int SWRST_LEN = SWRST_EXT_CYCLES
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        SRST,
	// axi4-lite write
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	// axi4-lite read
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	// system side
	input  wire logic        IDLE_MODE,
	output logic             WD_IRQ,
	output logic             IDLE_WAKE,
	output logic             SYS_RESET,
	output logic             RST_PIN,
	output logic             XTAL_READY,
	output logic             MULT_READY
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	wd_ctrl_t               ctrl_r;
	logic [7:0]             clk_ctrl_r;
	logic                   wd_int_en_r;
	logic [7:0]             pmr_r;
	wd_state_t              state_r;
	logic [WIDTH_CNT-1:0]   cnt_r;
	logic [19:0]            dly_r;
	logic [16:0]            warm_r;
	logic                   warm_busy_r;
	logic                   mult_pend_r;
	logic [6:0]             swrst_r;
	logic                   swrst_busy_r;
	logic                   wd_rst_r;
	logic [7:0]             aw_addr_r;
	logic                   aw_have_r;
	logic [31:0]            w_data_r;
	logic [3:0]             w_strb_r;
	logic                   w_have_r;
	logic                   mult_en_prev_r;
	logic                   mult_wait_r;

	// ----------------------------------------------------------------
	// axi write decode
	// ----------------------------------------------------------------
	wire        wr_go    = aw_have_r && w_have_r && !BVALID;
	wire        wr_b0    = wr_go && w_strb_r[0];
	wire        wr_ctrl  = wr_b0 && (aw_addr_r == ADDR_WD_CONTROL);
	wire        wr_clock_control_reg = wr_b0 && (aw_addr_r == ADDR_CLOCK_CTRL);
	wire        wr_eie   = wr_b0 && (aw_addr_r == ADDR_EXT_INT_EN);
	wire        wr_pmr   = wr_b0 && (aw_addr_r == ADDR_POWER_MGMT);
	wire        wr_flash = wr_b0 && (aw_addr_r == ADDR_FLASH_CTRL);
	wire        wr_hit   = (aw_addr_r[7:2] <= ADDR_STATUS[7:2]) && (aw_addr_r[1:0] == 2'h0);
	wire [7:0]  wb       = w_data_r[7:0];

	// ----------------------------------------------------------------
	// timeout selection
	// ----------------------------------------------------------------
	wire [1:0]  cd_sel   = clk_ctrl_r[BIT_CD_LO +: 2];
	// interval select in clock control bits 7:6
	// RQ19 select field
	wire [1:0]  wd_sel   = clk_ctrl_r[BIT_WD_SEL_LO +: 2];
	wire        mult_4x  = pmr_r[BIT_MULT_FACTOR];
	// cd 00 uses the multiplier column, 01 and 10 share a column
	// RQ17 divide 00 column
	wire [5:0]  exp_base = (cd_sel == 2'h3) ? 6'(EXP_BASE_CD11) :
	                       (cd_sel != 2'h0) ? 6'(EXP_BASE_CD10) :
	                       mult_4x ? 6'(EXP_BASE_4X) : 6'(EXP_BASE_2X);
	// RQ1 RQ2 exponent per select
	wire [5:0]  exp_sel  = exp_base + 6'(EXP_STEP) * {4'h0, wd_sel};
	wire [19:0] dly_len  = (cd_sel == 2'h3) ? DELAY_CD11 :
	                       (cd_sel != 2'h0) ? DELAY_CD10 :
	                       mult_4x ? DELAY_4X : DELAY_2X;
	wire [WIDTH_CNT-1:0] interval = WIDTH_CNT'(1) << exp_sel;
	// RQ9 counts in system clocks
	wire        cnt_done = (cnt_r == interval - WIDTH_CNT'(1));
	wire        dly_done = (dly_r == dly_len - 20'h00001);
	// RQ4 restart strobe
	wire        restart  = wr_ctrl && wb[BIT_RESTART];
	// expiry still flags when a restart lands on the same edge
	wire        int_set  = (state_r == WD_COUNT) && cnt_done;
	// RQ3 reset gated by enable
	wire        wd_fire  = (state_r == WD_DELAY) && dly_done && !restart && ctrl_r.rst_enable;
	wire        mult_rise = pmr_r[BIT_MULT_EN] && !mult_en_prev_r;

	// ----------------------------------------------------------------
	// axi handshakes
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
			BVALID    <= 1'b0;
			BRESP     <= RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= AWADDR;
			end else if (wr_go) begin
				aw_have_r <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_have_r <= 1'b1;
				w_data_r <= WDATA;
				w_strb_r <= WSTRB;
			end else if (wr_go) begin
				w_have_r <= 1'b0;
			end
			if (wr_go) begin
				BVALID <= 1'b1;
				BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// ready only while the holding slot is empty
	always_ff @(posedge CLK) begin
		if (SRST) begin
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
		end else begin
			AWREADY <= !aw_have_r && !(AWVALID && AWREADY);
			WREADY  <= !w_have_r && !(WVALID && WREADY);
		end
	end

	// read path, one outstanding
	wire        rd_hit = (ARADDR[7:2] <= ADDR_STATUS[7:2]) && (ARADDR[1:0] == 2'h0);
	wire [7:0]  rd_byte =
		(ARADDR == ADDR_WD_CONTROL) ? {4'h0, ctrl_r.int_flag, ctrl_r.rst_flag, ctrl_r.rst_enable, 1'b0} :
		(ARADDR == ADDR_CLOCK_CTRL) ? clk_ctrl_r :
		(ARADDR == ADDR_EXT_INT_EN) ? {3'h0, wd_int_en_r, 4'h0} :
		(ARADDR == ADDR_POWER_MGMT) ? pmr_r :
		(ARADDR == ADDR_STATUS)     ? {4'h0, mult_wait_r, warm_busy_r, swrst_busy_r, state_r[2:1] != 2'h0} :
		8'h00;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h00000000;
			RRESP   <= RESP_OKAY;
		end else begin
			ARREADY <= !RVALID && ARVALID && !ARREADY;
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA  <= {24'h000000, rd_byte};
				RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// any reset, including the watchdog's own, restores defaults
	always_ff @(posedge CLK) begin
		if (SRST || SYS_RESET) begin
			// RQ18 default divide ratio
			clk_ctrl_r  <= CLOCK_CTRL_RST | {6'h00, CD_RST};
			wd_int_en_r <= 1'b0;
			pmr_r       <= 8'h00;
		end else begin
			if (wr_clock_control_reg)
				clk_ctrl_r <= wb;
			if (wr_eie)
				wd_int_en_r <= wb[BIT_WD_INT_EN];
			if (wr_pmr)
				pmr_r <= wb;
		end
	end

	// sticky flags: hardware set wins over a software clear
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl_r.int_flag   <= 1'b0;
			ctrl_r.rst_flag   <= 1'b0;
			ctrl_r.rst_enable <= 1'b0;
		end else begin
			// RQ6 interval sets flag
			// RQ20 cleared only by write or SRST
			if (int_set)
				ctrl_r.int_flag <= 1'b1;
			else if (wr_ctrl)
				ctrl_r.int_flag <= wb[BIT_INT_FLAG];
			// RQ7 RQ22 reset flag survives
			if (wd_fire)
				ctrl_r.rst_flag <= 1'b1;
			else if (wr_ctrl)
				ctrl_r.rst_flag <= wb[BIT_RST_FLAG];
			// enable falls back to default on any reset, like the config
			if (SYS_RESET)
				ctrl_r.rst_enable <= 1'b0;
			else if (wr_ctrl)
				ctrl_r.rst_enable <= wb[BIT_RST_ENABLE];
		end
	end

	// ----------------------------------------------------------------
	// watchdog counter
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST || SYS_RESET || restart) begin
			// RQ21 restart clears both counts
			state_r <= WD_COUNT;
			cnt_r   <= '0;
			dly_r   <= 20'h00000;
		end else begin
			case (state_r)
				WD_COUNT: begin
					cnt_r <= cnt_done ? '0 : cnt_r + WIDTH_CNT'(1);
					if (cnt_done)
						state_r <= WD_DELAY;
				end
				WD_DELAY: begin
					// RQ5 masked reset keeps period
					dly_r <= dly_done ? 20'h00000 : dly_r + 20'h00001;
					cnt_r <= cnt_r + WIDTH_CNT'(1);
					if (dly_done)
						state_r <= ctrl_r.rst_enable ? WD_FIRE : WD_COUNT;
				end
				WD_FIRE: begin
					state_r <= WD_COUNT;
				end
				default: begin
					state_r <= WD_COUNT;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// startup counters
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			// RQ11 warm-up at power-up
			warm_busy_r    <= 1'b1;
			warm_r         <= 17'h00000;
			mult_en_prev_r <= 1'b0;
			mult_wait_r    <= 1'b0;
		end else begin
			mult_en_prev_r <= pmr_r[BIT_MULT_EN];
			// RQ11 restart after stop
			if (wr_pmr && wb[BIT_XTAL_RESTART]) begin
				warm_busy_r <= 1'b1;
				warm_r      <= 17'h00000;
			// RQ10 count crystal warm-up
			end else if (warm_busy_r) begin
				warm_r <= warm_r + 17'h00001;
				if (warm_r == 17'(XTAL_WARM - 1))
					warm_busy_r <= 1'b0;
			end
			// RQ12 watchdog-timed multiplier delay
			if (mult_rise)
				mult_wait_r <= 1'b1;
			else if (!pmr_r[BIT_MULT_EN] || int_set)
				mult_wait_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// system reset sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			swrst_busy_r <= 1'b0;
			swrst_r      <= 7'h00;
			wd_rst_r     <= 1'b0;
		end else begin
			wd_rst_r <= wd_fire;
			// RQ14 command starts reset
			if (wr_flash && wb == SYS_RESET_CMD && !swrst_busy_r) begin
				swrst_busy_r <= 1'b1;
				swrst_r      <= 7'h00;
			// RQ15 hold about 90 clocks
			end else if (swrst_busy_r) begin
				swrst_r <= swrst_r + 7'h01;
				if (swrst_r == 7'(SWRST_LEN - 1))
					swrst_busy_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			WD_IRQ     <= 1'b0;
			IDLE_WAKE  <= 1'b0;
			SYS_RESET  <= 1'b0;
			RST_PIN    <= 1'b0;
			XTAL_READY <= 1'b0;
			MULT_READY <= 1'b0;
		end else begin
			// RQ8 gated by enable
			WD_IRQ     <= ctrl_r.int_flag && wd_int_en_r;
			// RQ13 wake from idle
			IDLE_WAKE  <= ctrl_r.int_flag && wd_int_en_r && IDLE_MODE;
			// RQ16 pin low when done
			SYS_RESET  <= swrst_busy_r || wd_rst_r;
			RST_PIN    <= swrst_busy_r;
			XTAL_READY <= !warm_busy_r;
			MULT_READY <= pmr_r[BIT_MULT_EN] && !mult_wait_r && !mult_rise;
		end
	end

endmodule : watchdog_system_reset

// ### tb/watchdog_system_reset_props.sv
module watchdog_props
	import wdt_pkg::*;
#(
	parameter int XTAL_WARM = 16,
	parameter int SWRST_LEN = 8
) (
	// clock and reset
	input wire logic        CLK,
	input wire logic        SRST,
	// read bus and write response valid
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0]  RRESP,
	input wire logic        RVALID,
	input wire logic        BVALID,
	// system side
	input wire logic        IDLE_MODE,
	input wire logic        WD_IRQ,
	input wire logic        IDLE_WAKE,
	input wire logic        SYS_RESET,
	input wire logic        RST_PIN,
	input wire logic        XTAL_READY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);

	int warm_cnt;
	int pin_cnt;

	// ----------------------------------------------------------------
	// helper counters
	// ----------------------------------------------------------------
	// length of the current crystal-not-ready spell, and of the pin pulse
	always_ff @(posedge CLK) begin
		warm_cnt <= (SRST || XTAL_READY) ? 0 : warm_cnt + 1;
		pin_cnt <= (SRST || !RST_PIN) ? 0 : pin_cnt + 1;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	rst_clear_a: assert property ($past(SRST) |-> !WD_IRQ && !SYS_RESET && !RST_PIN && !XTAL_READY)
		else $error("outputs not clear after reset");
	pin_len_a: assert property ($fell(RST_PIN) |-> pin_cnt == SWRST_LEN)
		else $error("reset pin pulse has wrong length");
	pin_sys_a: assert property (RST_PIN |-> SYS_RESET)
		else $error("reset pin high outside system reset");
	xtal_warm_a: assert property ($rose(XTAL_READY) |-> warm_cnt >= XTAL_WARM)
		else $error("crystal ready before warm-up count");
	wake_mode_a: assert property (IDLE_WAKE |-> $past(IDLE_MODE))
		else $error("wake outside idle");
	irq_fall_a: assert property ($fell(WD_IRQ) |-> BVALID || $past(BVALID) || SYS_RESET || $past(SYS_RESET)
		|| $past(SYS_RESET, 2))
		else $error("interrupt dropped without software action");
	rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	err_data_a: assert property (RVALID && RRESP == RESP_SLVERR |-> RDATA == 32'h0)
		else $error("error read carries data");

	irq_c: cover property ($rose(WD_IRQ));
	wdrst_c: cover property ($rose(SYS_RESET) && !RST_PIN);
	swrst_c: cover property ($fell(RST_PIN));
endmodule : watchdog_props

bind watchdog_system_reset watchdog_props #(
	.XTAL_WARM(XTAL_WARM),
	.SWRST_LEN(SWRST_LEN)
) props_i (.CLK(CLK), .SRST(SRST), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
	.RVALID(RVALID), .BVALID(BVALID), .IDLE_MODE(IDLE_MODE), .WD_IRQ(WD_IRQ), .IDLE_WAKE(IDLE_WAKE),
	.SYS_RESET(SYS_RESET), .RST_PIN(RST_PIN), .XTAL_READY(XTAL_READY));

// ### tb/watchdog_and_system_reset_tb.sv
module watchdog_and_system_reset_tb
	import wdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, srst, awvalid, wvalid, bready, arvalid, rready, idle_mode;
	logic        awready, wready, bvalid, arready, rvalid, wd_irq, idle_wake, sys_reset, rst_pin, xtal_ready;
	logic        mult_ready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          fail_count, comparisons;

	// short warm-up and pulse keep the run brief
	watchdog_system_reset #(.XTAL_WARM(16), .SWRST_LEN(8)) uut (
		.CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
		.WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready), .IDLE_MODE(idle_mode), .WD_IRQ(wd_irq), .IDLE_WAKE(idle_wake), .SYS_RESET(sys_reset),
		.RST_PIN(rst_pin), .XTAL_READY(xtal_ready), .MULT_READY(mult_ready));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// address and data offered together, each released once taken
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	function logic sig(input int s);
		case (s)
			0: return wd_irq;
			1: return sys_reset;
			2: return rst_pin;
			default: return xtal_ready;
		endcase
	endfunction : sig

	// bounded wait, counting edges until the chosen output is high
	task until_hi(input int s, output int n);
		n = 0;
		while (sig(s) !== 1'b1 && n < 40000) begin
			@(posedge clk);
			n++;
		end
	endtask : until_hi

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		until_hi(3, n);
		chk("warm_len", 32'(n >= 15 && n < 40), 32'h1);
		wr(ADDR_POWER_MGMT, 32'h20, r);
		@(posedge clk);
		chk("xtal_restart", 32'(xtal_ready), 32'h0);
		until_hi(3, n);
		chk("rewarm_len", 32'(n >= 14 && n < 40), 32'h1);
		rd(ADDR_CLOCK_CTRL, d, r);
		chk("clk_ctrl_rst", d, 32'h02);
		wr(ADDR_CLOCK_CTRL, 32'hc1, r);
		rd(ADDR_CLOCK_CTRL, d, r);
		chk("wd_sel", d, 32'hc1);
		rd(ADDR_WD_CONTROL, d, r);
		chk("flags_rst", d & 32'h0c, 32'h0);
		rd(8'h18, d, r);
		chk("rd_unmapped", 32'(r), 32'(RESP_SLVERR));
		wr(8'h1c, 32'h0, r);
		chk("wr_unmapped", 32'(r), 32'(RESP_SLVERR));
		$display("test regs done");
	endtask : t_regs

	// divide 00 at 4X, reset masked, idle and multiplier wait on
	task t_irq;
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		wr(ADDR_CLOCK_CTRL, 32'h00, r);
		wr(ADDR_POWER_MGMT, 32'h14, r);
		wr(ADDR_EXT_INT_EN, 32'h10, r);
		// looked at a write later, once the multiplier wait can show
		chk("mult_wait", 32'(mult_ready), 32'h0);
		idle_mode <= 1'b1;
		wr(ADDR_WD_CONTROL, 32'h01, r);
		until_hi(0, n);
		chk("irq_time", 32'(n >= 32760 && n <= 32775), 32'h1);
		repeat (2) @(posedge clk);
		chk("wake", 32'(idle_wake), 32'h1);
		chk("mult_ready", 32'(mult_ready), 32'h1);
		rd(ADDR_WD_CONTROL, d, r);
		chk("int_flag", 32'(d[BIT_INT_FLAG]), 32'h1);
		n = 0;
		repeat (200) begin
			@(posedge clk);
			if (sys_reset !== 1'b0) n++;
		end
		chk("masked_reset", n, 0);
		wr(ADDR_EXT_INT_EN, 32'h00, r);
		repeat (2) @(posedge clk);
		chk("irq_masked", 32'(wd_irq), 32'h0);
		rd(ADDR_WD_CONTROL, d, r);
		chk("flag_kept", 32'(d[BIT_INT_FLAG]), 32'h1);
		idle_mode <= 1'b0;
		$display("test irq done");
	endtask : t_irq

	// restart must give a full interval before the reset
	task t_wdrst;
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		wr(ADDR_WD_CONTROL, 32'h03, r);
		until_hi(1, n);
		chk("wd_rst_time", 32'(n >= 32888 && n <= 32903), 32'h1);
		repeat (4) @(posedge clk);
		rd(ADDR_WD_CONTROL, d, r);
		chk("rst_flag", 32'(d[BIT_RST_FLAG]), 32'h1);
		rd(ADDR_CLOCK_CTRL, d, r);
		chk("cfg_default", d, 32'h02);
		wr(ADDR_WD_CONTROL, 32'h00, r);
		rd(ADDR_WD_CONTROL, d, r);
		chk("flag_clear", 32'(d[BIT_RST_FLAG]), 32'h0);
		$display("test watchdog reset done");
	endtask : t_wdrst

	task t_swrst;
		logic [1:0] r;
		int         n;
		wr(ADDR_FLASH_CTRL, 32'(SYS_RESET_CMD), r);
		until_hi(2, n);
		chk("pin_rise", 32'(n < 4), 32'h1);
		n = 0;
		while (rst_pin === 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("pin_len", n, 8);
		repeat (2) @(posedge clk);
		chk("sys_released", 32'(sys_reset), 32'h0);
		$display("test software reset done");
	endtask : t_swrst

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		{srst, awvalid, wvalid, bready, arvalid, rready, idle_mode} = 7'h40;
		{awaddr, araddr, wdata, wstrb} = 52'h0000000000001;
		fail_count = 0;
		comparisons = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_regs;
		t_irq;
		t_wdrst;
		t_swrst;
		report_and_stop;
	end

	// tests need about 66000 cycles
	initial begin
		repeat (80000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end
endmodule : watchdog_and_system_reset_tb
